//--- inc/fspc_pkg.sv
// constants, codes and types shared by the flash self programming control
package fspc_pkg;

  // clock and operation timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int ERASE_TIME_NS = 2000;
  localparam int WRITE_TIME_NS = 200;
  localparam int ERASE_CYC     = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC     = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // boot areas are groups of this many blocks
  localparam int SWAP_SPAN = 4;

  // vector layout in internal ram
  localparam logic [31:0] MI_VEC_OFS  = 32'h0000_0004;
  localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;
  localparam logic [31:0] INFO_RESET  = 32'h0000_0000;

  // synchroniser settle count before the mode strap is taken
  localparam logic [1:0] SETTLE_DONE = 2'h2;

  typedef enum logic [3:0] {
    FSPC_OP_ERASE     = 4'h0,
    FSPC_OP_WRITE     = 4'h1,
    FSPC_OP_VERIFY    = 4'h2,
    FSPC_OP_BLANK     = 4'h3,
    FSPC_OP_READ      = 4'h4,
    FSPC_OP_GET_INFO  = 4'h5,
    FSPC_OP_SET_INFO  = 4'h6,
    FSPC_OP_SWAP      = 4'h7,
    FSPC_OP_PIN_CHECK = 4'h8
  } fspc_op_t;

  typedef enum logic [1:0] {
    FSPC_IDLE   = 2'b00,
    FSPC_EXEC   = 2'b01,
    FSPC_FINISH = 2'b10
  } fspc_state_t;

  typedef enum logic [1:0] {
    FSPC_MODE_NORMAL     = 2'b00,
    FSPC_MODE_PROGRAMMER = 2'b01,
    FSPC_MODE_PROHIBITED = 2'b10
  } fspc_mode_t;

  typedef enum logic [2:0] {
    FSPC_ST_OK        = 3'h0,
    FSPC_ST_PROTECT   = 3'h1,
    FSPC_ST_MODE      = 3'h2,
    FSPC_ST_VERIFY    = 3'h3,
    FSPC_ST_BLANK     = 3'h4,
    FSPC_ST_BAD_OP    = 3'h5
  } fspc_status_t;

endpackage : fspc_pkg

//--- rtl/fspc_pin_sync.sv
// two flip-flop synchroniser for the mode pins
module fspc_pin_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } fspc_sync_t;

  fspc_sync_t s;
  fspc_sync_t next_s;

  // first stage feeds only the second
  always_comb begin
    next_s        = s;
    next_s.stage1 = async_in;
    next_s.stage2 = s.stage1;
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.stage2;
endmodule : fspc_pin_sync

//--- rtl/fspc_core.sv
// flash self programming sequencer with boot swap and vector redirect
module fspc_core
  import fspc_pkg::*;
#(
  parameter int          OFS_W         = 4,
  parameter int          BLK_W         = 4,
  parameter int          CNT_W         = 16,
  parameter logic [31:0] RAM_BASE      = 32'h03FF_D800,
  parameter logic [31:0] NMI_FLASH_VEC = 32'h0000_0010,
  parameter logic [31:0] MI_FLASH_VEC  = 32'h0000_0080
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   mode_protect_pin,
  input  wire logic                   aux_mode_pin,
  input  wire logic                   self_prog_req,
  input  wire logic                   op_start,
  input  wire logic [3:0]             op_code,
  input  wire logic [BLK_W-1:0]       op_block,
  input  wire logic [BLK_W+OFS_W-1:0] op_addr,
  input  wire logic [31:0]            op_wdata,
  input  wire logic [31:0]            arr_rdata,
  input  wire logic                   arr_margin_fail,
  output logic      [BLK_W+OFS_W-1:0] arr_addr,
  output logic      [31:0]            arr_wdata,
  output logic                        arr_write,
  output logic                        arr_erase,
  output logic                        arr_read,
  output logic                        busy,
  output logic                        done,
  output logic      [2:0]             status,
  output logic      [31:0]            rdata,
  output logic                        self_prog_active,
  output logic                        flash_fetch_ok,
  output logic      [31:0]            nmi_vector,
  output logic      [31:0]            mi_vector
);
  localparam int ADDR_W    = BLK_W + OFS_W;
  localparam int BLK_WORDS = 2 ** OFS_W;

  // elaboration checks
  if (BLK_W < 3) begin : g_chk_blk
    $error("fspc_core: BLK_W must cover blocks 0 to 7");
  end
  if (CNT_W <= OFS_W || ERASE_CYC >= 2 ** CNT_W || WRITE_CYC < 1) begin : g_chk_cnt
    $error("fspc_core: CNT_W too narrow for block walk or timing");
  end

  typedef struct packed {
    fspc_state_t       state;
    fspc_op_t          op;
    logic [BLK_W-1:0]  blk;
    logic [CNT_W-1:0]  cnt;
    logic [1:0]        settle;
    logic              mode_taken;
    fspc_mode_t        mode;
    logic              swapped;
    logic [31:0]       info;
    fspc_status_t      status;
    logic              done;
    logic [31:0]       rdata;
    logic [ADDR_W-1:0] arr_addr;
    logic [31:0]       arr_wdata;
    logic              arr_write;
    logic              arr_erase;
    logic              arr_read;
    logic              rd_pending;
    logic              sp_active;
    logic              busy;
    logic              fetch_ok;
    logic [31:0]       nmi_vec;
    logic [31:0]       mi_vec;
  } fspc_core_t;

  fspc_core_t s;
  fspc_core_t next_s;
  logic [1:0] pins_s;
  logic       pin_s;
  logic       aux_s;

  // pin synchroniser
  fspc_pin_sync #(.W(2)) u_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in ({aux_mode_pin, mode_protect_pin}),
    .sync_out (pins_s)
  );
  assign pin_s = pins_s[0];
  assign aux_s = pins_s[1];

  // logical to physical block, areas swapped when flagged
  function automatic logic [BLK_W-1:0] phys_block(input logic [BLK_W-1:0] b,
                                                  input logic sw);
    phys_block = b;
    if (sw && b < BLK_W'(2 * SWAP_SPAN)) begin
      phys_block = b ^ BLK_W'(SWAP_SPAN);
    end
  endfunction : phys_block

  // operations that change flash contents need the protect pin
  function automatic logic needs_protect(input logic [3:0] op);
    needs_protect = (op == FSPC_OP_ERASE) || (op == FSPC_OP_WRITE) ||
                    (op == FSPC_OP_SET_INFO) || (op == FSPC_OP_SWAP);
  endfunction : needs_protect

  // next state
  always_comb begin
    next_s           = s;
    next_s.done      = 1'b0;
    next_s.arr_write = 1'b0;
    next_s.arr_erase = 1'b0;
    next_s.arr_read  = 1'b0;
    // mode strap taken once synchronisers settle after release
    if (!s.mode_taken) begin
      if (s.settle == SETTLE_DONE) begin
        next_s.mode_taken = 1'b1;
        if (!pin_s) begin
          next_s.mode = FSPC_MODE_NORMAL;
        end else if (!aux_s) begin
          next_s.mode = FSPC_MODE_PROGRAMMER;
        end else begin
          next_s.mode = FSPC_MODE_PROHIBITED;
        end
      end else begin
        next_s.settle = s.settle + 2'h1;
      end
    end
    case (s.state)
      FSPC_IDLE: begin
        if (op_start) begin
          next_s.op     = fspc_op_t'(op_code);
          next_s.cnt    = '0;
          next_s.status = FSPC_ST_OK;
          next_s.state  = FSPC_FINISH;
          if (!s.sp_active) begin
            next_s.status = FSPC_ST_MODE;
          end else if (needs_protect(op_code) && !pin_s) begin
            next_s.status = FSPC_ST_PROTECT;
          end else begin
            case (op_code)
              FSPC_OP_ERASE: begin
                next_s.arr_erase = 1'b1;
                next_s.arr_addr  = {phys_block(op_block, s.swapped), {OFS_W{1'b0}}};
                next_s.cnt       = CNT_W'(ERASE_CYC);
                next_s.state     = FSPC_EXEC;
              end
              FSPC_OP_WRITE: begin
                next_s.arr_write = 1'b1;
                next_s.arr_addr  = {phys_block(op_addr[ADDR_W-1:OFS_W], s.swapped),
                                    op_addr[OFS_W-1:0]};
                next_s.arr_wdata = op_wdata;
                next_s.cnt       = CNT_W'(WRITE_CYC);
                next_s.state     = FSPC_EXEC;
              end
              FSPC_OP_VERIFY, FSPC_OP_BLANK: begin
                next_s.blk   = phys_block(op_block, s.swapped);
                next_s.state = FSPC_EXEC;
              end
              FSPC_OP_READ: begin
                next_s.arr_read   = 1'b1;
                next_s.arr_addr   = {phys_block(op_addr[ADDR_W-1:OFS_W], s.swapped),
                                     op_addr[OFS_W-1:0]};
                next_s.rd_pending = 1'b1;
                next_s.cnt        = CNT_W'(BLK_WORDS);
                next_s.state      = FSPC_EXEC;
              end
              FSPC_OP_GET_INFO: next_s.rdata = s.info;
              FSPC_OP_SET_INFO: next_s.info = op_wdata;
              FSPC_OP_SWAP: next_s.swapped = !s.swapped;
              FSPC_OP_PIN_CHECK: begin
                next_s.status = pin_s ? FSPC_ST_OK : FSPC_ST_PROTECT;
              end
              default: next_s.status = FSPC_ST_BAD_OP;
            endcase
          end
        end
      end
      FSPC_EXEC: begin
        if (s.op == FSPC_OP_ERASE || s.op == FSPC_OP_WRITE) begin
          // timed program or erase pulse
          if (s.cnt <= CNT_W'(1)) begin
            next_s.state = FSPC_FINISH;
          end else begin
            next_s.cnt = s.cnt - CNT_W'(1);
          end
        end else begin
          // data checks one cycle after each read
          if (s.rd_pending) begin
            if (s.op == FSPC_OP_BLANK && arr_rdata != ERASED_WORD) begin
              next_s.status = FSPC_ST_BLANK;
            end
            if (s.op == FSPC_OP_VERIFY && arr_margin_fail) begin
              next_s.status = FSPC_ST_VERIFY;
            end
            if (s.op == FSPC_OP_READ) begin
              next_s.rdata = arr_rdata;
            end
          end
          if (s.cnt != CNT_W'(BLK_WORDS)) begin
            next_s.arr_read   = 1'b1;
            next_s.arr_addr   = {s.blk, s.cnt[OFS_W-1:0]};
            next_s.cnt        = s.cnt + CNT_W'(1);
            next_s.rd_pending = 1'b1;
          end else begin
            next_s.rd_pending = 1'b0;
            if (!s.rd_pending) begin
              next_s.state = FSPC_FINISH;
            end
          end
        end
      end
      FSPC_FINISH: begin
        next_s.done  = 1'b1;
        next_s.state = FSPC_IDLE;
      end
      default: next_s.state = FSPC_IDLE;
    endcase
    // self programming held while an operation runs, normal mode only
    if (s.state == FSPC_IDLE) begin
      next_s.sp_active = self_prog_req && s.mode_taken && s.mode == FSPC_MODE_NORMAL;
    end
    next_s.busy     = next_s.state != FSPC_IDLE;
    next_s.fetch_ok = next_s.state == FSPC_IDLE;
    next_s.nmi_vec  = next_s.sp_active ? RAM_BASE : NMI_FLASH_VEC;
    next_s.mi_vec   = next_s.sp_active ? RAM_BASE + MI_VEC_OFS : MI_FLASH_VEC;
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s          <= '0;
      s.info     <= INFO_RESET;
      s.fetch_ok <= 1'b1;
      s.nmi_vec  <= NMI_FLASH_VEC;
      s.mi_vec   <= MI_FLASH_VEC;
    end else begin
      s <= next_s;
    end
  end

  assign arr_addr         = s.arr_addr;
  assign arr_wdata        = s.arr_wdata;
  assign arr_write        = s.arr_write;
  assign arr_erase        = s.arr_erase;
  assign arr_read         = s.arr_read;
  assign busy             = s.busy;
  assign done             = s.done;
  assign status           = s.status;
  assign rdata            = s.rdata;
  assign self_prog_active = s.sp_active;
  assign flash_fetch_ok   = s.fetch_ok;
  assign nmi_vector       = s.nmi_vec;
  assign mi_vector        = s.mi_vec;

  // checks
  localparam int ERASE_BOUND = ERASE_CYC + 2;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_busy_no_fetch: assert property (busy |-> !flash_fetch_ok)
    else $error("flash fetch allowed while busy");
  a_nmi_ram_vec: assert property (self_prog_active |-> nmi_vector == RAM_BASE)
    else $error("nmi vector not at ram start");
  a_mi_ram_vec: assert property (self_prog_active |-> mi_vector == RAM_BASE + MI_VEC_OFS)
    else $error("maskable vector not at ram start plus four");
  a_erase_protect: assert property (arr_erase |-> $past(pin_s))
    else $error("erase issued with protect pin low");
  a_write_protect: assert property (arr_write |-> $past(pin_s))
    else $error("write issued with protect pin low");
  a_mode_normal_only: assert property (self_prog_active |-> s.mode == FSPC_MODE_NORMAL)
    else $error("self programming outside normal mode");
  a_swap_map_erase: assert property (
    (s.state == FSPC_IDLE && op_start && op_code == FSPC_OP_ERASE && op_block == '0 &&
     s.swapped && s.sp_active && pin_s) |=>
    (arr_erase && arr_addr[ADDR_W-1:OFS_W] == BLK_W'(SWAP_SPAN)))
    else $error("swapped block 0 not mapped to block 4");
  a_erase_done_time: assert property ($rose(arr_erase) |-> ##[1:ERASE_BOUND] done)
    else $error("erase did not complete in time");
  a_done_one_cycle: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_pin_check_low: assert property (
    (s.state == FSPC_IDLE && op_start && op_code == FSPC_OP_PIN_CHECK && s.sp_active &&
     !pin_s) |-> ##2 (done && status == FSPC_ST_PROTECT))
    else $error("pin check did not report protect");

  c_erase_done: cover property ($rose(arr_erase) ##[1:ERASE_BOUND] done);
  c_blank_fail: cover property (done && status == FSPC_ST_BLANK);
  c_swap: cover property ($rose(s.swapped));
  c_read_done: cover property (s.op == FSPC_OP_READ && done && status == FSPC_ST_OK);
endmodule : fspc_core

//--- verification/fspc_testbench.sv
// self-checking bench for the flash self programming control
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("BAD %0t got %h exp %h", $time, got, exp); end end

module testbench
  import fspc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        nrst, pin, aux, req, start, margin, lk, bz;
  logic [3:0]  code, blk;
  logic [7:0]  addr, arr_addr, ers_addr;
  logic [31:0] wdata, arr_rdata, arr_wdata, rdata, nmi_vec, mi_vec;
  logic        arr_write, arr_erase, arr_read, busy, done, active, fetch_ok;
  logic [2:0]  status;
  logic [31:0] mem [256] = '{default: 32'h0};
  int          n_errors, check_count, cycles, n, nr;

  // 100 MHz clock
  always #5 clk = ~clk;

  fspc_core DUT (
    .clk             (clk),
    .nrst            (nrst),
    .mode_protect_pin(pin),
    .aux_mode_pin    (aux),
    .self_prog_req   (req),
    .op_start        (start),
    .op_code         (code),
    .op_block        (blk),
    .op_addr         (addr),
    .op_wdata        (wdata),
    .arr_rdata       (arr_rdata),
    .arr_margin_fail (margin),
    .arr_addr        (arr_addr),
    .arr_wdata       (arr_wdata),
    .arr_write       (arr_write),
    .arr_erase       (arr_erase),
    .arr_read        (arr_read),
    .busy            (busy),
    .done            (done),
    .status          (status),
    .rdata           (rdata),
    .self_prog_active(active),
    .flash_fetch_ok  (fetch_ok),
    .nmi_vector      (nmi_vec),
    .mi_vector       (mi_vec)
  );

  // flash array: combinational read of the registered address, no added latency
  assign arr_rdata = mem[arr_addr];

  // erase fills a whole block, write stores one word
  always @(posedge clk) begin
    if (arr_erase) begin
      ers_addr <= arr_addr;
      for (int i = 0; i < 16; i++) begin
        mem[{arr_addr[7:4], i[3:0]}] <= 32'hFFFF_FFFF;
      end
    end
    if (arr_write) begin
      mem[arr_addr] <= arr_wdata;
    end
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      $display("BAD %0t timeout", $time);
      close_out();
    end
  end

  task automatic close_out;
    if (n_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // reset with the mode pins strapped, outputs checked while held
  task automatic do_reset(input logic p, input logic a);
    @(negedge clk);
    nrst = 1'b0;
    pin  = p;
    aux  = a;
    repeat (5) @(negedge clk);
    `CHK(fetch_ok, 1'b1)
    `CHK(nmi_vec, 32'h0000_0010)
    `CHK(mi_vec, 32'h0000_0080)
    nrst = 1'b1;
    repeat (8) @(negedge clk);
  endtask : do_reset

  // one operation; n counts edges from the taking edge to done
  task automatic run_op(input logic [3:0] c, input logic [3:0] b, input logic [7:0] a,
                        input logic [31:0] d);
    code  = c;
    blk   = b;
    addr  = a;
    wdata = d;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    n     = 1;
    nr    = 0;
    lk    = 1'b0;
    bz    = 1'b0;
    // stimulus idles while busy, timers left to the service
    while (done !== 1'b1 && n < 400) begin
      if (busy === 1'b1 && fetch_ok !== 1'b0) lk = 1'b1;
      if (busy === 1'b1) bz = 1'b1;
      if (arr_read === 1'b1) nr++;
      @(negedge clk);
      n++;
    end
  endtask : run_op

  // programmer strap and prohibited strap never allow self programming
  task automatic t_straps;
    req = 1'b1;
    for (int m = 1; m < 3; m++) begin
      do_reset(1'b1, m == 2);
      `CHK(active, 1'b0)
      run_op(FSPC_OP_READ, 4'h0, 8'h00, 32'h0);
      `CHK(status, FSPC_ST_MODE)
    end
  endtask : t_straps

  // normal strap; vectors follow the self programming state
  task automatic t_mode;
    req = 1'b0;
    do_reset(1'b0, 1'b1);
    run_op(FSPC_OP_READ, 4'h0, 8'h00, 32'h0);
    `CHK(status, FSPC_ST_MODE)
    req = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(active, 1'b1)
    `CHK(nmi_vec, 32'h03FF_D800)
    `CHK(mi_vec, 32'h03FF_D804)
  endtask : t_mode

  // protect pin low blocks rewrites, pin check reports the level
  task automatic t_protect;
    run_op(FSPC_OP_ERASE, 4'h2, 8'h00, 32'h0);
    `CHK(status, FSPC_ST_PROTECT)
    `CHK(mem[8'h20], 32'h0)
    run_op(FSPC_OP_SET_INFO, 4'h0, 8'h00, 32'h1);
    `CHK(status, FSPC_ST_PROTECT)
    run_op(FSPC_OP_PIN_CHECK, 4'h0, 8'h00, 32'h0);
    `CHK(status, FSPC_ST_PROTECT)
    pin = 1'b1;
    repeat (3) @(negedge clk);
    run_op(FSPC_OP_PIN_CHECK, 4'h0, 8'h00, 32'h0);
    `CHK(status, FSPC_ST_OK)
    `CHK(n, 2)
  endtask : t_protect

  // erase then back-to-back blank check and verify
  task automatic t_erase;
    run_op(FSPC_OP_ERASE, 4'h2, 8'h00, 32'h0);
    `CHK(n, ERASE_CYC + 2)
    `CHK(lk, 1'b0)
    `CHK(bz, 1'b1)
    `CHK(busy, 1'b0)
    `CHK(status, FSPC_ST_OK)
    `CHK(ers_addr, 8'h20)
    run_op(FSPC_OP_BLANK, 4'h2, 8'h00, 32'h0);
    `CHK(n, 20)
    `CHK(nr, 16)
    `CHK(status, FSPC_ST_OK)
    run_op(FSPC_OP_VERIFY, 4'h2, 8'h00, 32'h0);
    `CHK(status, FSPC_ST_OK)
    margin = 1'b1;
    run_op(FSPC_OP_VERIFY, 4'h2, 8'h00, 32'h0);
    margin = 1'b0;
    `CHK(status, FSPC_ST_VERIFY)
  endtask : t_erase

  // word write, read back, and a block that is no longer blank
  task automatic t_write;
    run_op(FSPC_OP_WRITE, 4'h0, 8'h25, 32'h1234_5678);
    `CHK(n, WRITE_CYC + 2)
    `CHK(mem[8'h25], 32'h1234_5678)
    run_op(FSPC_OP_READ, 4'h0, 8'h25, 32'h0);
    `CHK(n, 4)
    `CHK(nr, 1)
    `CHK(rdata, 32'h1234_5678)
    run_op(FSPC_OP_BLANK, 4'h2, 8'h00, 32'h0);
    `CHK(status, FSPC_ST_BLANK)
  endtask : t_write

  // boot swap exchanges blocks 0-3 with 4-7 in both directions
  task automatic t_swap;
    run_op(FSPC_OP_SWAP, 4'h0, 8'h00, 32'h0);
    `CHK(status, FSPC_ST_OK)
    run_op(FSPC_OP_WRITE, 4'h0, 8'h13, 32'hA5A5_5A5A);
    `CHK(mem[8'h53], 32'hA5A5_5A5A)
    run_op(FSPC_OP_READ, 4'h0, 8'h13, 32'h0);
    `CHK(rdata, 32'hA5A5_5A5A)
    run_op(FSPC_OP_ERASE, 4'h6, 8'h00, 32'h0);
    `CHK(ers_addr, 8'h20)
    run_op(FSPC_OP_ERASE, 4'h0, 8'h00, 32'h0);
    `CHK(ers_addr, 8'h40)
  endtask : t_swap

  // flash information round trip and an unknown code
  task automatic t_misc;
    run_op(FSPC_OP_SET_INFO, 4'h0, 8'h00, 32'hC3C3_3C3C);
    run_op(FSPC_OP_GET_INFO, 4'h0, 8'h00, 32'h0);
    `CHK(rdata, 32'hC3C3_3C3C)
    run_op(4'h9, 4'h0, 8'h00, 32'h0);
    `CHK(status, FSPC_ST_BAD_OP)
  endtask : t_misc

  // main sequence
  initial begin
    nrst   = 1'b0;
    pin    = 1'b0;
    aux    = 1'b0;
    req    = 1'b0;
    start  = 1'b0;
    margin = 1'b0;
    code   = 4'h0;
    blk    = 4'h0;
    addr   = 8'h00;
    wdata  = 32'h0;
    t_straps();
    t_mode();
    t_protect();
    t_erase();
    t_write();
    t_swap();
    t_misc();
    pin = 1'b0; // protect pin back low once done
    close_out();
  end
endmodule : testbench
